// ==== design/fes_pkg.sv ====
// Constants, types and command tables shared by the erase and protect sequencer
package fes_pkg;

  // Flash window and block geometry
  localparam logic [31:0] FLASH_BASE = 32'h1FC0_0000;
  localparam int BLK_SHIFT = 17;
  localparam int HALF_BIT = 19;
  localparam logic [31:0] VERIFY_OFS = 32'h0000_0010;

  // Own register map, byte offsets on the AHB-Lite port
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_MASK = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0C;
  localparam logic [7:0] REG_RDATA = 8'h10;

  // Status register field positions
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_WINDOW = 3;
  localparam int ST_MISSED = 4;
  localparam int ST_PROT = 5;
  localparam int ST_ABORT = 6;
  localparam int ST_REFUSED = 7;
  localparam int ST_VMODE = 8;
  localparam int ST_READY = 9;

  // Device status word bits
  localparam int POLL_BIT = 7;
  localparam int LIMIT_BIT = 5;
  localparam int WINDOW_BIT = 3;

  // Command sequence values
  localparam logic [31:0] UNLOCK_ADDR1 = 32'h0000_5554;
  localparam logic [31:0] UNLOCK_ADDR2 = 32'h0000_AAA8;
  localparam logic [31:0] UNLOCK_DATA1 = 32'h0000_00AA;
  localparam logic [31:0] UNLOCK_DATA2 = 32'h0000_0055;
  localparam logic [31:0] ERASE_SETUP = 32'h0000_0080;
  localparam logic [31:0] CHIP_ERASE_DATA = 32'h0000_0010;
  localparam logic [31:0] BLK_ERASE_DATA = 32'h0000_0030;
  localparam logic [31:0] RESET_DATA = 32'h0000_00F0;
  localparam logic [31:0] VERIFY_SETUP = 32'h0000_0090;
  localparam logic [31:0] PROT_ADDR [0:6] = '{32'h0000_5554, 32'h0000_AAA8, 32'h0000_5554,
    32'h0000_5554, 32'h0000_AAA8, 32'h0000_5554, 32'h0000_0000};
  localparam logic [31:0] PROT_DATA [0:6] = '{32'h0000_00AA, 32'h0000_0055, 32'h0000_009A,
    32'h0000_00AA, 32'h0000_0055, 32'h0000_009A, 32'h0000_009A};
  localparam logic [31:0] UNPROT_ADDR [0:6] = '{32'h0000_5554, 32'h0000_AAA8, 32'h0000_5554,
    32'h0000_5554, 32'h0000_AAA8, 32'h0000_5554, 32'h0000_0000};
  localparam logic [31:0] UNPROT_DATA [0:6] = '{32'h0000_00AA, 32'h0000_0055, 32'h0000_009A,
    32'h0000_00AA, 32'h0000_0055, 32'h0000_009A, 32'h0000_006A};

  // Cycle counts less one, as last cycle index
  localparam logic [2:0] LAST_ERASE = 3'h5;
  localparam logic [2:0] LAST_PROT = 3'h6;
  localparam logic [2:0] LAST_VERIFY = 3'h3;

  // Hardware reset pulse towards the flash
  localparam int CLK_PERIOD_NS = 25;
  localparam int RST_TIME_NS = 1000;
  localparam logic [7:0] RST_CYCLES = 8'((RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [3:0] {
    CMD_NONE = 4'h0,
    CMD_CHIP_ERASE = 4'h1,
    CMD_BLK_ERASE = 4'h2,
    CMD_PROTECT = 4'h3,
    CMD_UNPROTECT = 4'h4,
    CMD_VERIFY = 4'h5,
    CMD_VERIFY_NEXT = 4'h6,
    CMD_SW_RESET = 4'h7,
    CMD_HW_RESET = 4'h8,
    CMD_READ = 4'h9
  } fes_cmd_type;

  // One bus cycle towards the flash command port
  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } fes_fl_req_type;

endpackage : fes_pkg

// ==== design/fes_bus_cycle.sv ====
// One flash bus cycle: holds the request until the flash acknowledges it or an abort drops it
module fes_bus_cycle
  import fes_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Sequencer side
  input wire logic start,
  input wire logic abort,
  input wire logic we,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  output logic done,
  output logic [31:0] rdata,
  // Flash side
  output fes_fl_req_type fl_req,
  input wire logic fl_ack,
  input wire logic [31:0] fl_rdata
);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      fl_req <= '0;
      done <= 1'b0;
      rdata <= 32'h0000_0000;
    end
    else
    begin
      done <= 1'b0;
      if (abort)
      begin
        fl_req.req <= 1'b0;
      end
      else if (fl_req.req && fl_ack)
      begin
        fl_req.req <= 1'b0;
        done <= 1'b1;
        if (!fl_req.we)
        begin
          rdata <= fl_rdata;
        end
      end
      else if (start && !fl_req.req)
      begin
        fl_req.req <= 1'b1;
        fl_req.we <= we;
        fl_req.addr <= addr;
        fl_req.wdata <= wdata;
      end
    end
  end

endmodule : fes_bus_cycle

// ==== design/fes_sequencer.sv ====
// Host-side erase, protect and status sequencer with an AHB-Lite register port
//
// How it works
// - Chip erase is sent as six write cycles; the flash starts at once.
// - Chip erase targets one half; A19 carries the half on every cycle.
// - Hardware reset order aborts everything; status shows the abort for a retry.
// - Erase failure leaves the flash locked; host flags fail, software sends reset.
// - Extra blocks of the same half are added while the window is open.
// - Unprotect targets one half selected by A19 on the command cycles.
// - Verify is four cycles; the fourth is a full word read of the block.
// - Verify address has A3..A0 zero, A4 one and A6 zero.
// - Status is read at a block address with A1 and A0 zero.
// - Bit 3 is checked before and after each added block erase.
//
// Chosen here: the placing of the registers and register access over AHB-Lite.
module fes_sequencer
  import fes_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Flash command port
  output fes_fl_req_type fl_req,
  input wire logic fl_ack,
  input wire logic [31:0] fl_rdata,
  input wire logic fl_ready,
  output logic fl_reset_n
);

  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_SEQ = 6'h02,
    S_CHECK = 6'h04,
    S_POLL = 6'h08,
    S_WAITRDY = 6'h10,
    S_HWRST = 6'h20
  } fes_state_type;

  fes_state_type state;
  fes_cmd_type cur_cmd;
  fes_cmd_type cmd_val;
  logic cmd_wr;
  logic [31:0] addr_reg;
  logic [3:0] mask_reg;
  logic dp_write;
  logic [7:0] dp_addr;
  logic [2:0] cyc;
  logic cyc_wait;
  logic [3:0] pend;
  logic [1:0] cur_blk;
  logic half;
  logic second;
  logic seen_low;
  logic [7:0] rst_cnt;
  logic [31:0] rdata_reg;
  logic st_done;
  logic st_fail;
  logic st_window;
  logic st_missed;
  logic st_prot;
  logic st_abort;
  logic st_refused;
  logic verify_mode;
  logic accept;
  logic eng_start;
  logic eng_we;
  logic [31:0] eng_addr;
  logic [31:0] eng_wdata;
  logic eng_done;
  logic [31:0] eng_rdata;
  logic [31:0] seq_off;
  logic [31:0] seq_data;
  logic seq_last;
  logic seq_read;
  logic [31:0] blk_base;
  logic [31:0] stat_word;
  logic [3:0] start_mask;
  logic [1:0] first_blk;

  // Commands in flight are never interrupted except by a hardware reset
  assign accept = cmd_wr && (state == S_IDLE || cmd_val == CMD_HW_RESET);

  // Block being addressed; status reads use it with A1..A0 clear
  assign blk_base = {12'h000, half, cur_blk, 17'h00000};

  // A block mask of zero falls back to the single block in the address
  always_comb
  begin
    start_mask = (mask_reg == 4'h0) ? 4'(1 << addr_reg[18:17]) : mask_reg;
    first_blk = 2'h0;
    for (int i = 3; i >= 0; i--)
    begin
      if (pend[i])
      begin
        first_blk = 2'(i);
      end
    end
  end

  // Address and data of the current command cycle
  always_comb
  begin
    seq_off = 32'h0000_0000;
    seq_data = 32'h0000_0000;
    seq_last = 1'b0;
    seq_read = 1'b0;
    case (cur_cmd)
      CMD_CHIP_ERASE, CMD_BLK_ERASE:
      begin
        case (cyc)
          3'h0, 3'h3:
          begin
            seq_off = UNLOCK_ADDR1;
            seq_data = UNLOCK_DATA1;
          end
          3'h1, 3'h4:
          begin
            seq_off = UNLOCK_ADDR2;
            seq_data = UNLOCK_DATA2;
          end
          3'h2:
          begin
            seq_off = UNLOCK_ADDR1;
            seq_data = ERASE_SETUP;
          end
          default:
          begin
            seq_off = (cur_cmd == CMD_CHIP_ERASE) ? UNLOCK_ADDR1 : blk_base;
            seq_data = (cur_cmd == CMD_CHIP_ERASE) ? CHIP_ERASE_DATA : BLK_ERASE_DATA;
          end
        endcase
        seq_last = (cyc == LAST_ERASE);
      end
      CMD_PROTECT:
      begin
        seq_off = (cyc == LAST_PROT) ? blk_base : PROT_ADDR[cyc];
        seq_data = PROT_DATA[cyc];
        seq_last = (cyc == LAST_PROT);
      end
      CMD_UNPROTECT:
      begin
        seq_off = UNPROT_ADDR[cyc];
        seq_data = UNPROT_DATA[cyc];
        seq_last = (cyc == LAST_PROT);
      end
      CMD_VERIFY:
      begin
        case (cyc)
          3'h0:
          begin
            seq_off = UNLOCK_ADDR1;
            seq_data = UNLOCK_DATA1;
          end
          3'h1:
          begin
            seq_off = UNLOCK_ADDR2;
            seq_data = UNLOCK_DATA2;
          end
          3'h2:
          begin
            seq_off = UNLOCK_ADDR1;
            seq_data = VERIFY_SETUP;
          end
          default:
          begin
            seq_off = blk_base | VERIFY_OFS;
            seq_read = 1'b1;
          end
        endcase
        seq_last = (cyc == LAST_VERIFY);
      end
      CMD_VERIFY_NEXT:
      begin
        seq_off = blk_base | VERIFY_OFS;
        seq_read = 1'b1;
        seq_last = 1'b1;
      end
      CMD_READ:
      begin
        seq_off = {12'h000, addr_reg[19:2], 2'b00};
        seq_read = 1'b1;
        seq_last = 1'b1;
      end
      CMD_SW_RESET:
      begin
        seq_data = RESET_DATA;
        seq_last = 1'b1;
      end
      default:
      begin
        seq_last = 1'b1;
      end
    endcase
  end

  // Requests towards the bus cycle engine; A19 rides on every cycle
  always_comb
  begin
    eng_start = (state == S_SEQ || state == S_CHECK || state == S_POLL) && !cyc_wait;
    eng_we = (state == S_SEQ) && !seq_read;
    eng_wdata = seq_data;
    if (state == S_SEQ)
    begin
      eng_addr = FLASH_BASE | seq_off | {12'h000, half, 19'h00000};
    end
    else
    begin
      eng_addr = FLASH_BASE | blk_base;
    end
  end

  fes_bus_cycle u_cycle (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(eng_start),
    .abort(accept && cmd_val == CMD_HW_RESET),
    .we(eng_we),
    .addr(eng_addr),
    .wdata(eng_wdata),
    .done(eng_done),
    .rdata(eng_rdata),
    .fl_req(fl_req),
    .fl_ack(fl_ack),
    .fl_rdata(fl_rdata)
  );

  // Command sequencer and status flags
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state <= S_IDLE;
      cur_cmd <= CMD_NONE;
      cyc <= 3'h0;
      cyc_wait <= 1'b0;
      pend <= 4'h0;
      cur_blk <= 2'h0;
      half <= 1'b0;
      second <= 1'b0;
      seen_low <= 1'b0;
      rst_cnt <= 8'h00;
      fl_reset_n <= 1'b1;
      rdata_reg <= 32'h0000_0000;
      st_done <= 1'b0;
      st_fail <= 1'b0;
      st_window <= 1'b0;
      st_missed <= 1'b0;
      st_prot <= 1'b0;
      st_abort <= 1'b0;
      st_refused <= 1'b0;
      verify_mode <= 1'b0;
    end
    else
    begin
      if (eng_start)
      begin
        cyc_wait <= 1'b1;
      end
      if (eng_done)
      begin
        cyc_wait <= 1'b0;
      end
      if (eng_done && !eng_we)
      begin
        rdata_reg <= eng_rdata;
      end
      if (cmd_wr && !accept)
      begin
        st_refused <= 1'b1;
      end
      if (accept)
      begin
        cur_cmd <= cmd_val;
        cyc <= 3'h0;
        cyc_wait <= 1'b0;
        second <= 1'b0;
        seen_low <= 1'b0;
        half <= addr_reg[HALF_BIT];
        cur_blk <= addr_reg[18:17];
        pend <= start_mask;
        st_done <= 1'b0;
        st_fail <= 1'b0;
        st_missed <= 1'b0;
        st_refused <= 1'b0;
        if (cmd_val == CMD_HW_RESET)
        begin
          st_abort <= (state != S_IDLE);
          rst_cnt <= RST_CYCLES;
          fl_reset_n <= 1'b0;
          state <= S_HWRST;
        end
        else
        begin
          st_abort <= 1'b0;
          if (cmd_val == CMD_BLK_ERASE)
          begin
            cur_blk <= 2'(start_mask[0] ? 0 : start_mask[1] ? 1 : start_mask[2] ? 2 : 3);
          end
          state <= S_SEQ;
        end
      end
      else
      begin
        case (state)
          S_IDLE:
          begin
            state <= S_IDLE;
          end
          S_SEQ:
          begin
            if (eng_done)
            begin
              if (!seq_last)
              begin
                cyc <= cyc + 3'h1;
              end
              else
              begin
                case (cur_cmd)
                  CMD_CHIP_ERASE:
                  begin
                    state <= S_POLL;
                  end
                  CMD_BLK_ERASE:
                  begin
                    pend[cur_blk] <= 1'b0;
                    state <= S_CHECK;
                  end
                  CMD_PROTECT, CMD_UNPROTECT:
                  begin
                    state <= S_WAITRDY;
                  end
                  CMD_VERIFY, CMD_VERIFY_NEXT:
                  begin
                    st_prot <= eng_rdata[0];
                    verify_mode <= 1'b1;
                    st_done <= 1'b1;
                    state <= S_IDLE;
                  end
                  CMD_SW_RESET:
                  begin
                    verify_mode <= 1'b0;
                    st_done <= 1'b1;
                    state <= S_IDLE;
                  end
                  default:
                  begin
                    st_done <= 1'b1;
                    state <= S_IDLE;
                  end
                endcase
              end
            end
          end
          S_CHECK:
          begin
            if (eng_done)
            begin
              st_window <= eng_rdata[WINDOW_BIT];
              if (pend != 4'h0 && !eng_rdata[WINDOW_BIT])
              begin
                cur_blk <= first_blk;
                cyc <= 3'h0;
                state <= S_SEQ;
              end
              else
              begin
                st_missed <= (pend != 4'h0);
                state <= S_POLL;
              end
            end
          end
          S_POLL:
          begin
            if (eng_done)
            begin
              if (eng_rdata[POLL_BIT])
              begin
                st_done <= 1'b1;
                state <= S_IDLE;
              end
              else if (eng_rdata[LIMIT_BIT] && second)
              begin
                st_fail <= 1'b1;
                state <= S_IDLE;
              end
              else
              begin
                second <= eng_rdata[LIMIT_BIT];
              end
            end
          end
          S_WAITRDY:
          begin
            if (!fl_ready)
            begin
              seen_low <= 1'b1;
            end
            else if (seen_low)
            begin
              st_done <= 1'b1;
              state <= S_IDLE;
            end
          end
          S_HWRST:
          begin
            if (rst_cnt == 8'h01)
            begin
              fl_reset_n <= 1'b1;
              verify_mode <= 1'b0;
              state <= S_IDLE;
            end
            rst_cnt <= rst_cnt - 8'h01;
          end
          default:
          begin
            state <= S_IDLE;
          end
        endcase
      end
    end
  end

  always_comb
  begin
    stat_word = 32'h0000_0000;
    stat_word[ST_BUSY] = (state != S_IDLE);
    stat_word[ST_DONE] = st_done;
    stat_word[ST_FAIL] = st_fail;
    stat_word[ST_WINDOW] = st_window;
    stat_word[ST_MISSED] = st_missed;
    stat_word[ST_PROT] = st_prot;
    stat_word[ST_ABORT] = st_abort;
    stat_word[ST_REFUSED] = st_refused;
    stat_word[ST_VMODE] = verify_mode;
    stat_word[ST_READY] = fl_ready;
  end

  // AHB-Lite slave: zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
      dp_write <= 1'b0;
      dp_addr <= 8'h00;
      cmd_wr <= 1'b0;
      cmd_val <= CMD_NONE;
      addr_reg <= 32'h0000_0000;
      mask_reg <= 4'h0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      cmd_wr <= 1'b0;
      dp_write <= hsel && htrans[1] && hready && hwrite;
      dp_addr <= haddr[7:0];
      if (hsel && htrans[1] && hready && !hwrite)
      begin
        case (haddr[7:0])
          REG_ADDR: hrdata <= addr_reg;
          REG_MASK: hrdata <= {28'h0000000, mask_reg};
          REG_STAT: hrdata <= stat_word;
          REG_RDATA: hrdata <= rdata_reg;
          default: hrdata <= 32'h0000_0000;
        endcase
      end
      if (dp_write)
      begin
        case (dp_addr)
          REG_CTRL:
          begin
            cmd_wr <= 1'b1;
            cmd_val <= fes_cmd_type'(hwdata[3:0]);
          end
          REG_ADDR: addr_reg <= hwdata;
          REG_MASK: mask_reg <= hwdata[3:0];
          default: addr_reg <= addr_reg;
        endcase
      end
    end
  end

endmodule : fes_sequencer

// ==== bench/fes_seq_asserts.sv ====
// Concurrent checks on the sequencer ports
module fes_seq_asserts
  import fes_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Flash command port
  input wire fes_fl_req_type fl_req,
  input wire logic fl_ack,
  input wire logic [31:0] fl_rdata,
  input wire logic fl_ready,
  input wire logic fl_reset_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] low_cnt;
  // Length of the current flash reset pulse
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      low_cnt <= 8'h00;
    else if (!fl_reset_n)
      low_cnt <= low_cnt + 8'h01;
    else
      low_cnt <= 8'h00;
  end
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  AST_BUS_OKAY:
    assert property (hreadyout && !hresp) else $error("bus wait or error");
  AST_REQ_HOLD:
    assert property (fl_req.req && !fl_ack |=> !fl_reset_n || (fl_req.req && $stable(fl_req)))
    else $error("flash request changed before ack");
  AST_REQ_DROP:
    assert property (fl_req.req && fl_ack |=> !fl_req.req) else $error("request kept after ack");
  AST_RST_LEN:
    assert property ($rose(fl_reset_n) |-> low_cnt == RST_CYCLES) else $error("reset pulse length");
  AST_RST_QUIET:
    assert property (!fl_reset_n && !$past(fl_reset_n) |-> !fl_req.req)
    else $error("request during flash reset");
  AST_CMD_BYTE:
    assert property (fl_req.req && fl_req.we |-> fl_req.wdata[31:8] == 24'h0
      && fl_req.addr[31:20] == FLASH_BASE[31:20]) else $error("bad command write");
  AST_RD_ALIGN:
    assert property (fl_req.req && !fl_req.we |-> fl_req.addr[1:0] == 2'b00)
    else $error("unaligned flash read");
  AST_RD_HOLD:
    assert property (!(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
    else $error("read data changed");
  COV_CHIP: cover property (fl_req.req && fl_ack && fl_req.wdata[7:0] == CHIP_ERASE_DATA[7:0]);
  COV_PROT: cover property (!fl_ready ##1 fl_ready);
  COV_HWRST: cover property ($fell(fl_reset_n));
endmodule : fes_seq_asserts

// ==== bench/fes_flash_model.sv ====
// Behavioural flash: command decode, timers and status word
module fes_flash_model
  import fes_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Flash port
  input wire fes_fl_req_type fl_req,
  output logic fl_ack,
  output logic [31:0] fl_rdata,
  output logic fl_ready,
  input wire logic fl_reset_n,
  // Scenario controls
  input wire logic [1:0] dly,
  input wire logic fail_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] ERASE_T = 8'h3C;
  localparam logic [7:0] WIN_T = 8'hA0;
  localparam logic [7:0] PROT_T = 8'h1E;
  logic [2:0] n;
  logic [7:0] tmr;
  logic [7:0] prot;
  logic [7:0] d;
  logic [1:0] cnt;
  logic busy, win, pbusy, fail, vmode, wflag;
  assign d = fl_req.wdata[7:0];
  assign fl_ready = !(busy || pbusy);
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn || !fl_reset_n)
    begin
      {fl_ack, cnt, n, tmr, busy, win, pbusy, fail, vmode, wflag} <= '0;
      fl_rdata <= 32'h0;
      if (!hresetn)
        prot <= 8'h00;
    end
    else
    begin
      fl_ack <= 1'b0;
      fl_rdata <= ~fl_rdata;
      if (tmr != 8'h00)
        tmr <= tmr - 8'h01;
      if (win && tmr == 8'h00)
      begin
        win <= 1'b0;
        busy <= 1'b1;
        wflag <= 1'b1;
        tmr <= ERASE_T;
      end
      else if (busy && tmr == 8'h00)
      begin
        busy <= fail_mode;
        fail <= fail_mode;
      end
      if (pbusy && tmr == 8'h00)
        pbusy <= 1'b0;
      if (fl_req.req && !fl_ack && cnt >= dly)
      begin
        fl_ack <= 1'b1;
        cnt <= 2'h0;
        // No program orders arrive, so no program polling
        if (!fl_req.we)
          fl_rdata <= vmode ? {31'h0, prot[fl_req.addr[19:17]]}
            : (busy || win || pbusy) ? {26'h0, fail, 1'b0, wflag, 3'h0}
            : 32'hFFFF_FFFF;
        else if (!(busy && !fail) && !pbusy)
        begin
          n <= n + 3'h1;
          if (d == RESET_DATA[7:0])
            {n, vmode, busy, fail, win} <= '0;
          else if (win && !(d inside {UNLOCK_DATA1[7:0], UNLOCK_DATA2[7:0], ERASE_SETUP[7:0],
            BLK_ERASE_DATA[7:0]}))
            {n, win, wflag} <= '0;
          else if (n == 3'h2 && d == VERIFY_SETUP[7:0])
            {n, vmode} <= {3'h0, 1'b1};
          else if (n == 3'h5 && d == CHIP_ERASE_DATA[7:0])
            {n, busy, wflag, tmr} <= {3'h0, 2'b11, ERASE_T};
          else if (n == 3'h5 && d == BLK_ERASE_DATA[7:0])
            {n, win, wflag, tmr} <= {3'h0, 2'b10, WIN_T};
          else if (n == 3'h6)
          begin
            {n, pbusy, tmr} <= {3'h0, 1'b1, PROT_T};
            if (d == PROT_DATA[6][7:0])
              prot[fl_req.addr[19:17]] <= 1'b1;
            else
              prot[{fl_req.addr[19], 2'b00} +: 4] <= 4'h0;
          end
        end
      end
      else if (fl_req.req && !fl_ack)
        cnt <= cnt + 2'h1;
    end
  end
endmodule : fes_flash_model

// ==== bench/fes_sequencer_tb.sv ====
// Self-checking bench for the erase and protect sequencer
module fes_sequencer_tb
  import fes_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, fl_ack, fl_ready, fl_reset_n, fail_mode;
  logic exp19;
  logic [1:0] htrans, dly;
  logic [31:0] haddr, hwdata, hrdata, fl_rdata, rd;
  fes_fl_req_type fl_req;
  int errors, checked, nwr, bad19;
  fes_sequencer i_fes_sequencer (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fl_req(fl_req), .fl_ack(fl_ack),
    .fl_rdata(fl_rdata), .fl_ready(fl_ready), .fl_reset_n(fl_reset_n));
  fes_flash_model i_fes_flash_model (.hclk(hclk), .hresetn(hresetn), .fl_req(fl_req),
    .fl_ack(fl_ack), .fl_rdata(fl_rdata), .fl_ready(fl_ready), .fl_reset_n(fl_reset_n),
    .dly(dly), .fail_mode(fail_mode));
  // Counts flash writes and their half-array bit
  always @(posedge hclk)
  begin
    if (fl_req.req && fl_ack && fl_req.we)
    begin
      nwr = nwr + 1;
      if (fl_req.addr[HALF_BIT] !== exp19)
        bad19 = bad19 + 1;
    end
  end
  task stop_test;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task bus_wait;
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1)
    begin
      errors++;
      stop_test();
    end
  endtask : bus_wait
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    bus_wait();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    bus_wait();
    rd = hrdata;
  endtask : ahb
  task wait_idle;
    int n;
    n = 0;
    ahb(1'b0, REG_STAT, 32'h0);
    do
    begin
      ahb(1'b0, REG_STAT, 32'h0);
      n++;
    end
    while (rd[ST_BUSY] !== 1'b0 && n < 400);
    if (rd[ST_BUSY] !== 1'b0)
    begin
      errors++;
      stop_test();
    end
  endtask : wait_idle
  task run(input logic [3:0] cmd, input logic [31:0] mask, input logic [31:0] val);
    nwr = 0;
    bad19 = 0;
    ahb(1'b1, REG_CTRL, {28'h0, cmd});
    wait_idle();
    check("status", val, rd & mask);
  endtask : run
  task t_reset;
    ahb(1'b0, REG_STAT, 32'h0);
    check("idle status", 32'h200, rd & 32'h201);
    ahb(1'b0, 8'h20, 32'h0);
    check("unmapped", 32'h0, rd);
  endtask : t_reset
  task t_chip;
    dly = 2'h2;
    exp19 = 1'b1;
    ahb(1'b1, REG_ADDR, 32'h0008_0000);
    run(CMD_CHIP_ERASE, 32'h7, 32'h2);
    check("chip writes", 32'd6, nwr);
    check("half bit", 32'd0, bad19);
  endtask : t_chip
  task t_refuse;
    ahb(1'b1, REG_CTRL, {28'h0, CMD_CHIP_ERASE});
    run(CMD_BLK_ERASE, 32'h83, 32'h82);
  endtask : t_refuse
  task t_block;
    dly = 2'h1;
    exp19 = 1'b0;
    ahb(1'b1, REG_ADDR, 32'h0);
    ahb(1'b1, REG_MASK, 32'h5);
    run(CMD_BLK_ERASE, 32'h1F, 32'h2);
    check("block writes", 32'd12, nwr);
    check("half bit", 32'd0, bad19);
    ahb(1'b1, REG_MASK, 32'h0);
  endtask : t_block
  task t_protect;
    dly = 2'h0;
    ahb(1'b1, REG_ADDR, 32'h0004_0000);
    run(CMD_PROTECT, 32'h5, 32'h0);
    check("protect writes", 32'd7, nwr);
    run(CMD_VERIFY, 32'h120, 32'h120);
    ahb(1'b1, REG_ADDR, 32'h0002_0000);
    run(CMD_VERIFY_NEXT, 32'h120, 32'h100);
    run(CMD_SW_RESET, 32'h100, 32'h0);
    ahb(1'b1, REG_ADDR, 32'h0004_0000);
    run(CMD_UNPROTECT, 32'h5, 32'h0);
    run(CMD_VERIFY, 32'h120, 32'h100);
    run(CMD_SW_RESET, 32'h100, 32'h0);
  endtask : t_protect
  task t_fail;
    fail_mode = 1'b1;
    run(CMD_CHIP_ERASE, 32'h7, 32'h4);
    fail_mode = 1'b0;
    run(CMD_SW_RESET, 32'h5, 32'h0);
    check("reset writes", 32'd1, nwr);
    run(CMD_READ, 32'h5, 32'h0);
    ahb(1'b0, REG_RDATA, 32'h0);
    check("array word", 32'hFFFF_FFFF, rd);
  endtask : t_fail
  task t_hwreset;
    ahb(1'b1, REG_CTRL, {28'h0, CMD_CHIP_ERASE});
    run(CMD_HW_RESET, 32'h40, 32'h40);
    run(CMD_CHIP_ERASE, 32'h47, 32'h2);
  endtask : t_hwreset
  initial
  begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  initial
  begin
    {hresetn, hsel, hwrite, fail_mode, exp19} = '0;
    htrans = 2'b00;
    dly = 2'b00;
    haddr = 32'h0;
    hwdata = 32'h0;
    {errors, checked, nwr, bad19} = '0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_chip();
    t_refuse();
    t_block();
    t_protect();
    t_fail();
    t_hwreset();
    stop_test();
  end
endmodule : fes_sequencer_tb
bind fes_sequencer fes_seq_asserts i_fes_seq_asserts (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .fl_req(fl_req), .fl_ack(fl_ack), .fl_rdata(fl_rdata), .fl_ready(fl_ready),
  .fl_reset_n(fl_reset_n));
